/* File: common/sccl_pkg.sv */
package sccl_pkg;

    // Setup chain length and its bit counter
    localparam int unsigned CFG_BITS = 72;
    localparam int unsigned CNT_W    = $clog2(CFG_BITS);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CFG_BITS - 1);

    // Values taken by default programming and after reset
    localparam logic [CFG_BITS-1:0] CFG_DEFAULT = '0;

    // Number of pins that pass the two-flop synchroniser
    localparam int unsigned PIN_W = 5;

    // Loader progress
    typedef enum logic [1:0] {
        ST_MRESET,
        ST_LOAD,
        ST_DONE
    } sccl_state_t;

    // Pins that arrive from outside the clock domain
    typedef struct packed {
        logic serial_clk;
        logic serial_data;
        logic chain_enable_in_n;
        logic master_reset_n;
        logic serial_sel;
    } sccl_pins_t;

endpackage

/* File: rtl/sccl_sync.sv */
`timescale 1ns/1ps
module sccl_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // Two flops per bit; the first is read by the second only
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end else begin
                meta_ff[i] <= async_i[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    assign sync_o = sync_ff;

endmodule

/* File: rtl/sccl_loader.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: With serial mode strapped at master reset, a data bit is taken on each serial clock rise while the chain enable in is low.
// RULE2: Setup values live in a shift register that moves one place per taken bit.
// RULE3: Chain enable out goes low once serial or default programming is done and chain enable in is low.
// RULE4: After programming, chain enable out follows chain enable in both ways.
// RULE5: A low chain enable out means setup is done and queue traffic may start.
// RULE6: Once loaded with chain enable out low, serial data in is passed on to serial data out.
// RULE7: In a cascade each enable in comes from the previous enable out and each data in from the previous data out.
// RULE8: The controller treats the last device's enable out going low as the end of the whole chain load.
// RULE9: All serial clocks of a chain come from one source.
// RULE10: The last device's serial data out is left open.
// RULE11: The write queue address enable is not raised before programming ends and enable out is low.
// RULE12: With enable in high or without serial mode, serial clock edges leave the setup registers alone.
module sccl_loader (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          resetn_i,
    // Serial chain pins
    input  wire logic                          serial_clk_i,
    input  wire logic                          serial_data_i,
    input  wire logic                          chain_enable_in_n_i,
    output logic                               chain_enable_out_n_o,
    output logic                               serial_data_o,
    // Master reset and mode strap
    input  wire logic                          master_reset_n_i,
    input  wire logic                          serial_sel_i,
    // Setup values and status to the queue core
    output logic [sccl_pkg::CFG_BITS-1:0]      cfg_data_o,
    output logic                               cfg_done_o,
    output logic                               queue_op_ready_o
);

    sccl_pkg::sccl_pins_t              pins_raw;
    sccl_pkg::sccl_pins_t              pins_s;
    logic [sccl_pkg::PIN_W-1:0]        pins_sync;

    sccl_pkg::sccl_state_t             state_ff;
    sccl_pkg::sccl_state_t             nxt_state;
    logic                              serial_mode_ff;
    logic                              sclk_prev_ff;
    logic [sccl_pkg::CNT_W-1:0]        cnt_ff;
    logic [sccl_pkg::CNT_W-1:0]        nxt_cnt;
    logic [sccl_pkg::CFG_BITS-1:0]     cfg_ff;
    logic [sccl_pkg::CFG_BITS-1:0]     nxt_cfg;
    logic                              enout_n_ff;
    logic                              so_ff;
    logic                              done_ff;
    logic                              ready_ff;

    // Gather pins into one carrier and synchronise them together
    assign pins_raw.serial_clk        = serial_clk_i;
    assign pins_raw.serial_data       = serial_data_i;
    assign pins_raw.chain_enable_in_n = chain_enable_in_n_i;
    assign pins_raw.master_reset_n    = master_reset_n_i;
    assign pins_raw.serial_sel        = serial_sel_i;

    sccl_sync #(
        .W (sccl_pkg::PIN_W)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  (pins_raw),
        .sync_o   (pins_sync)
    );

    assign pins_s = sccl_pkg::sccl_pins_t'(pins_sync);

    // Decoding of edges and shift condition
    wire sclk_rise  = pins_s.serial_clk & ~sclk_prev_ff;
    wire in_mreset  = ~pins_s.master_reset_n;
    wire loading    = (state_ff == sccl_pkg::ST_LOAD);
    wire done_now   = (state_ff == sccl_pkg::ST_DONE);
    wire shift_en   = loading & sclk_rise & ~pins_s.chain_enable_in_n; // RULE1 RULE12
    wire last_bit   = shift_en & (cnt_ff == sccl_pkg::CNT_LAST);

    // Data and clock share one synchroniser, so the sampled bit lines up with the edge
    assign nxt_cfg = in_mreset ? sccl_pkg::CFG_DEFAULT
                   : shift_en  ? {cfg_ff[sccl_pkg::CFG_BITS-2:0], pins_s.serial_data} // RULE2
                   : cfg_ff; // RULE12

    assign nxt_cnt = (in_mreset | ~loading) ? sccl_pkg::CNT_ZERO
                   : shift_en ? (cnt_ff + sccl_pkg::CNT_ONE)
                   : cnt_ff;

    // Next state: master reset dominates; default mode skips loading
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            sccl_pkg::ST_MRESET: begin
                if (!in_mreset) begin
                    nxt_state = serial_mode_ff ? sccl_pkg::ST_LOAD : sccl_pkg::ST_DONE;
                end
            end
            sccl_pkg::ST_LOAD: begin
                if (last_bit) begin
                    nxt_state = sccl_pkg::ST_DONE;
                end
            end
            sccl_pkg::ST_DONE: begin
                nxt_state = state_ff;
            end
            default: begin
                nxt_state = sccl_pkg::ST_MRESET;
            end
        endcase
        if (in_mreset) begin
            nxt_state = sccl_pkg::ST_MRESET;
        end
    end

    // State, counter and setup shift register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff     <= sccl_pkg::ST_MRESET;
            cnt_ff       <= sccl_pkg::CNT_ZERO;
            cfg_ff       <= sccl_pkg::CFG_DEFAULT;
            sclk_prev_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            cfg_ff       <= nxt_cfg;
            sclk_prev_ff <= pins_s.serial_clk;
        end
    end

    // Mode strap caught while master reset is held, not at async reset
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_mode_ff <= 1'b0;
        end else if (in_mreset) begin
            serial_mode_ff <= pins_s.serial_sel;
        end
    end

    // Chain enable out stays high until done, then follows enable in
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enout_n_ff <= 1'b1;
            done_ff    <= 1'b0;
            ready_ff   <= 1'b0;
        end else begin
            enout_n_ff <= ~done_now | pins_s.chain_enable_in_n; // RULE3 RULE4
            done_ff    <= done_now;
            ready_ff   <= done_now & ~pins_s.chain_enable_in_n; // RULE5
        end
    end

    // Pass-through to the next device; held low otherwise so an open pin is quiet
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so_ff <= 1'b0;
        end else begin
            so_ff <= (done_now & ~enout_n_ff) ? pins_s.serial_data : 1'b0; // RULE6
        end
    end

    assign chain_enable_out_n_o = enout_n_ff;
    assign serial_data_o        = so_ff;
    assign cfg_data_o           = cfg_ff;
    assign cfg_done_o           = done_ff;
    assign queue_op_ready_o     = ready_ff;

    // Checks on the loader behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_shift;
        loading && sclk_rise && !pins_s.chain_enable_in_n && pins_s.master_reset_n;
    endsequence

    sequence s_final_shift;
        s_shift ##0 (cnt_ff == sccl_pkg::CNT_LAST);
    endsequence

    a_shift_capture: assert property ( // RULE1
        s_shift |=> cfg_ff[0] == $past(pins_s.serial_data)
    ) else $error("serial bit not captured on clock rise");

    a_shift_advance: assert property ( // RULE2
        s_shift |=> cfg_ff[sccl_pkg::CFG_BITS-1:1] == $past(cfg_ff[sccl_pkg::CFG_BITS-2:0])
    ) else $error("setup register did not advance by one");

    a_load_finish: assert property ( // RULE2
        s_final_shift |=> done_now ##1 done_ff
    ) else $error("load did not finish after the last bit");

    a_shift_ignore: assert property ( // RULE12
        (!shift_en && pins_s.master_reset_n && state_ff != sccl_pkg::ST_MRESET) |=> $stable(cfg_ff)
    ) else $error("setup changed without an enabled shift");

    a_enout_low: assert property ( // RULE3
        (done_now && !pins_s.chain_enable_in_n) |=> !chain_enable_out_n_o
    ) else $error("enable out not low after programming");

    a_enout_busy: assert property ( // RULE3
        !done_now |=> chain_enable_out_n_o
    ) else $error("enable out low before programming done");

    a_enout_follow: assert property ( // RULE4
        (done_now && $changed(pins_s.chain_enable_in_n)) |=>
        chain_enable_out_n_o == $past(pins_s.chain_enable_in_n)
    ) else $error("enable out failed to follow enable in");

    a_ready_state: assert property ( // RULE5
        queue_op_ready_o |-> (cfg_done_o && !chain_enable_out_n_o)
    ) else $error("ready without done and low enable out");

    a_pass_through: assert property ( // RULE6
        (done_now && !enout_n_ff) |=> serial_data_o == $past(pins_s.serial_data)
    ) else $error("serial data not passed through");

endmodule

/* File: verif/sccl_ctrl_model.sv */
`timescale 1ns/1ps
// Configuration controller on the far side of the chain
// No input for serial data out: the last device's data out is left open
module sccl_ctrl_model (
    // Clock
    input  wire logic clk_i,
    // Chain pins
    input  wire logic chain_enable_out_n_i,
    output logic      serial_clk_o,
    output logic      serial_data_o,
    output logic      chain_enable_in_n_o,
    // Queue side of the controller
    output logic      write_queue_addr_enable_o
);
    // Idle chain: clock still, enable off, no queue select
    initial begin
        serial_clk_o              = 1'b0;
        serial_data_o             = 1'b0;
        chain_enable_in_n_o       = 1'b1;
        write_queue_addr_enable_o = 1'b0;
    end

    // Last enable out low is the only sign that the whole chain is loaded
    task automatic wait_chain_done(input int limit, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++) begin
            @(negedge clk_i);
            seen = !chain_enable_out_n_i;
        end
        // Queue select only after the chain reports done
        if (seen) begin
            write_queue_addr_enable_o <= 1'b1;
        end
    endtask

    // Drop queue select before a new master reset
    task automatic close_queue();
        @(posedge clk_i);
        write_queue_addr_enable_o <= 1'b0;
    endtask

    // Only the first device's enable is ours to drive
    task automatic set_enable(input logic v);
        @(posedge clk_i);
        chain_enable_in_n_o <= v;
    endtask

    // 64 ns serial clock, stands still between frames; top bit goes first
    task automatic send(input logic [sccl_pkg::CFG_BITS-1:0] bits, input int n);
        @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_o <= bits[i];
            repeat (4) @(posedge clk_i);
            serial_clk_o <= ~serial_clk_o;
            repeat (4) @(posedge clk_i);
            serial_clk_o <= ~serial_clk_o;
        end
        // Released line flips so a stale bit cannot pass for a real one
        serial_data_o <= ~serial_data_o;
    endtask

    // Level for pass-through checks
    task automatic put_data(input logic v);
        @(posedge clk_i);
        serial_data_o <= v;
    endtask
endmodule

/* File: verif/sccl_loader_tb_top.sv */
`timescale 1ns/1ps
module sccl_loader_tb_top;
    logic                          clk_i, resetn_i, master_reset_n_i, serial_sel_i;
    logic                          sclk, sdata, en_in_n, en_out_n, sdo, done, ready, wq_en;
    logic [sccl_pkg::CFG_BITS-1:0] cfg;
    int                            num_errors = 0;
    int                            num_checks = 0;
    int                            cycles     = 0;
    localparam logic [71:0]        PAT_A = 72'ha50f3c96017e2dc4b8;
    localparam logic [71:0]        PAT_B = 72'h5ac3f0e1d2b4968778;

    sccl_loader sccl_loader_inst (.clk_i(clk_i), .resetn_i(resetn_i), .serial_clk_i(sclk),
        .serial_data_i(sdata), .chain_enable_in_n_i(en_in_n), .chain_enable_out_n_o(en_out_n),
        .serial_data_o(sdo), .master_reset_n_i(master_reset_n_i), .serial_sel_i(serial_sel_i),
        .cfg_data_o(cfg), .cfg_done_o(done), .queue_op_ready_o(ready));
    sccl_ctrl_model sccl_ctrl_model_inst (.clk_i(clk_i), .chain_enable_out_n_i(en_out_n),
        .serial_clk_o(sclk), .serial_data_o(sdata), .chain_enable_in_n_o(en_in_n),
        .write_queue_addr_enable_o(wq_en));

    // 125 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Hang guard, well above the under one thousand cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Settle past the edge so registered outputs have landed
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic status(input logic d, input logic o, input logic r);
        chk("cfg_done_o", {71'h0, d}, {71'h0, done});
        chk("chain_enable_out_n_o", {71'h0, o}, {71'h0, en_out_n});
        chk("queue_op_ready_o", {71'h0, r}, {71'h0, ready});
    endtask

    task automatic mreset(input logic sel);
        sccl_ctrl_model_inst.close_queue();
        @(posedge clk_i);
        master_reset_n_i <= 1'b0;
        serial_sel_i     <= sel;
        repeat (6) @(posedge clk_i);
        master_reset_n_i <= 1'b1;
        wait_cyc(6);
    endtask

    // Ignored bits, then 71 and the 72nd bit
    task automatic t_serial_load();
        logic seen;
        sccl_ctrl_model_inst.set_enable(1'b1);
        mreset(1'b1);
        sccl_ctrl_model_inst.send(PAT_B, 8);
        wait_cyc(4);
        chk("cfg_data_o", 72'h0, cfg);
        status(1'b0, 1'b1, 1'b0);
        sccl_ctrl_model_inst.set_enable(1'b0);
        sccl_ctrl_model_inst.send(PAT_A >> 1, 71);
        wait_cyc(4);
        chk("cfg_data_o", {1'b0, PAT_A[71:1]}, cfg);
        status(1'b0, 1'b1, 1'b0);
        chk("write_queue_addr_enable", 72'h0, {71'h0, wq_en});
        sccl_ctrl_model_inst.send(PAT_A, 1);
        sccl_ctrl_model_inst.wait_chain_done(8, seen);
        chk("chain_done_seen", 72'h1, {71'h0, seen});
        wait_cyc(2);
        chk("cfg_data_o", PAT_A, cfg);
        status(1'b1, 1'b0, 1'b1);
        chk("write_queue_addr_enable", 72'h1, {71'h0, wq_en});
    endtask

    // Enable following and pass-through once loaded
    task automatic t_follow();
        sccl_ctrl_model_inst.set_enable(1'b1);
        wait_cyc(4);
        status(1'b1, 1'b1, 1'b0);
        sccl_ctrl_model_inst.send(PAT_B, 3);
        wait_cyc(4);
        chk("cfg_data_o", PAT_A, cfg);
        chk("serial_data_o", 72'h0, {71'h0, sdo});
        sccl_ctrl_model_inst.set_enable(1'b0);
        wait_cyc(4);
        status(1'b1, 1'b0, 1'b1);
        for (int k = 0; k < 2; k++) begin
            sccl_ctrl_model_inst.put_data(k != 0);
            wait_cyc(4);
            chk("serial_data_o", {71'h0, k != 0}, {71'h0, sdo});
        end
    endtask

    // Default programming: done at once, serial edges ignored
    task automatic t_default_mode();
        sccl_ctrl_model_inst.set_enable(1'b1);
        mreset(1'b0);
        chk("cfg_data_o", sccl_pkg::CFG_DEFAULT, cfg);
        status(1'b1, 1'b1, 1'b0);
        sccl_ctrl_model_inst.set_enable(1'b0);
        wait_cyc(4);
        status(1'b1, 1'b0, 1'b1);
        sccl_ctrl_model_inst.send(PAT_B, 4);
        wait_cyc(4);
        chk("cfg_data_o", sccl_pkg::CFG_DEFAULT, cfg);
    endtask

    // Reset in mid-run: outputs fall back at once, then default programming again
    task automatic t_async_reset();
        @(posedge clk_i);
        resetn_i         <= 1'b0;
        master_reset_n_i <= 1'b0;
        wait_cyc(2);
        status(1'b0, 1'b1, 1'b0);
        chk("cfg_data_o", 72'h0, cfg);
        chk("serial_data_o", 72'h0, {71'h0, sdo});
        @(posedge clk_i);
        resetn_i <= 1'b1;
        mreset(1'b0);
        status(1'b1, 1'b0, 1'b1);
    endtask

    initial begin
        resetn_i         = 1'b0;
        master_reset_n_i = 1'b0;
        serial_sel_i     = 1'b0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_serial_load();
        t_follow();
        t_default_mode();
        t_async_reset();
        end_of_test();
    end
endmodule
